// ### core/rxcfg_pkg.sv
// Package with register map, field layout, reset values and timing for the receiver settings
package rxcfg_pkg;
	localparam int DATA_W = 8;
	localparam int BUS_W = 32;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_ALERT = 6'h0F;
	localparam logic [IDX_W-1:0] IDX_FILTER = 6'h10;
	localparam logic [IDX_W-1:0] IDX_POLY = 6'h11;
	localparam logic [IDX_W-1:0] IDX_SYNC = 6'h12;
	localparam logic [IDX_W-1:0] IDX_FLOOR = 6'h13;
	localparam logic [IDX_W-1:0] IDX_RSSI = 6'h14;
	localparam logic [IDX_W-1:0] IDX_DYN = 6'h15;
	// Reset values
	localparam logic [DATA_W-1:0] RST_ALERT = 8'h00;
	localparam logic [DATA_W-1:0] RST_FILTER = 8'hA3;
	localparam logic [DATA_W-1:0] RST_POLY = 8'h38;
	localparam logic [DATA_W-1:0] RST_SYNC = 8'h18;
	localparam logic [DATA_W-1:0] RST_FLOOR = 8'h04;
	localparam logic [DATA_W-1:0] RST_DYN = 8'h00;
	// Field positions
	localparam int F_HI_MSB = 7;
	localparam int F_HI_LSB = 4;
	localparam int F_LO_MSB = 3;
	localparam int F_LO_LSB = 0;
	localparam int F_POLY_EN = 7;
	localparam int F_BSYNC_OFF = 6;
	localparam int F_SYNC_EN = 5;
	localparam int F_SSIZE_MSB = 4;
	localparam int F_SSIZE_LSB = 3;
	localparam int F_STOL_MSB = 2;
	localparam int F_STOL_LSB = 1;
	localparam int F_STEP_MSB = 7;
	localparam int F_STEP_LSB = 5;
	localparam int F_RATE_MSB = 4;
	localparam int F_RATE_LSB = 2;
	localparam int F_AVG_MSB = 1;
	localparam int F_AVG_LSB = 0;
	// Sync sizes
	localparam logic [1:0] SSIZE_8 = 2'h0;
	localparam logic [1:0] SSIZE_16 = 2'h1;
	localparam logic [1:0] SSIZE_24 = 2'h2;
	localparam int SYNC_W = 32;
	localparam logic [5:0] SYNC_BITS_8 = 6'h08;
	localparam logic [5:0] SYNC_BITS_16 = 6'h10;
	localparam logic [5:0] SYNC_BITS_24 = 6'h18;
	localparam logic [5:0] SYNC_BITS_32 = 6'h20;
	// Threshold mode encoding from the demodulator
	typedef enum logic [1:0] {RXCFG_FIXED, RXCFG_PEAK, RXCFG_AVERAGE} rxcfg_mode_t;
	// Decrement rate: codes below this count chips, codes at or above count sub-chip ticks
	localparam logic [2:0] RATE_FAST = 3'h4;
	localparam logic [3:0] SUB_PER_CHIP = 4'hF;
endpackage : rxcfg_pkg

// ### core/rxcfg_sync_match.sv
// Sync word correlator with selectable length and bit error tolerance
`timescale 1ns/10ps
`default_nettype none
module rxcfg_sync_match (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Settings
	input wire logic syncEnable,
	input wire logic [1:0] syncSize,
	input wire logic [1:0] syncTolerance,
	input wire logic [rxcfg_pkg::SYNC_W-1:0] syncValue,
	// Demodulated bit stream
	input wire logic rxBit,
	input wire logic rxBitValid,
	// Result
	output logic syncFound
);
	import rxcfg_pkg::*;
	logic [SYNC_W-1:0] shiftReg;
	logic [SYNC_W-1:0] shiftNext;
	logic [5:0] bitsSeen;
	logic [SYNC_W-1:0] pattern;
	logic [SYNC_W-1:0] careMask;
	logic [SYNC_W-1:0] diff;
	logic [5:0] needBits;
	logic [5:0] errCount;
	logic next_syncFound;

	// Pattern taken most significant byte first, right aligned to the newest bits
	assign pattern = (syncSize == SSIZE_8) ? {24'h00_0000, syncValue[31:24]} :
		(syncSize == SSIZE_16) ? {16'h0000, syncValue[31:16]} :
		(syncSize == SSIZE_24) ? {8'h00, syncValue[31:8]} : syncValue;
	assign needBits = (syncSize == SSIZE_8) ? SYNC_BITS_8 : (syncSize == SSIZE_16) ?
		SYNC_BITS_16 : (syncSize == SSIZE_24) ? SYNC_BITS_24 : SYNC_BITS_32;

	// Compare including the bit arriving now, so the pulse follows that strobe
	assign shiftNext = {shiftReg[SYNC_W-2:0], rxBit};

	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_bit
			assign careMask[g] = (6'(g) < needBits);
			assign diff[g] = careMask[g] & (shiftNext[g] ^ pattern[g]);
		end
	endgenerate

	always_comb begin
		errCount = 6'h00;
		for (int i = 0; i < SYNC_W; i++) begin
			errCount = errCount + 6'(diff[i]);
		end
	end

	// Match tolerates up to the programmed number of wrong bits
	assign next_syncFound = syncEnable && rxBitValid && (bitsSeen >= needBits - 6'h01) &&
		(errCount <= {4'h0, syncTolerance});

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shiftReg <= '0;
			bitsSeen <= 6'h00;
			syncFound <= 1'b0;
		end else begin
			syncFound <= next_syncFound;
			if (rxBitValid) begin
				shiftReg <= shiftNext;
				if (bitsSeen < SYNC_BITS_32)
					bitsSeen <= bitsSeen + 6'h01;
			end
			if (!syncEnable)
				bitsSeen <= 6'h00;
		end
	end
endmodule : rxcfg_sync_match
`default_nettype wire

// ### core/rxcfg_onoff_threshold_floor.sv
// OOK slicing threshold: fixed, peak with timed decay to a floor, or average
`timescale 1ns/10ps
`default_nettype none
module rxcfg_onoff_threshold_floor (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Settings
	input wire rxcfg_pkg::rxcfg_mode_t mode,
	input wire logic [rxcfg_pkg::DATA_W-1:0] floorLevel,
	input wire logic [2:0] decSize,
	input wire logic [2:0] decRate,
	// Demodulator timing and strength
	input wire logic chipTick,
	input wire logic subTick,
	input wire logic [rxcfg_pkg::DATA_W-1:0] rssi,
	input wire logic [rxcfg_pkg::DATA_W-1:0] rssiAverage,
	// Result
	output logic [rxcfg_pkg::DATA_W-1:0] threshold
);
	import rxcfg_pkg::*;
	logic [3:0] tickCount;
	logic [3:0] tickLimit;
	logic tickSrc;
	logic decNow;
	logic [DATA_W-1:0] stepHalfDb;
	logic [DATA_W:0] lowered;
	logic [DATA_W-1:0] next_threshold;

	// Step in half-dB units: 0.5..2.0 dB then 3..6 dB
	assign stepHalfDb = decSize[2] ? 8'(({5'h00, decSize[1:0]} + 8'h03) << 1) :
		8'({5'h00, decSize[1:0]} + 8'h01);
	// Slow codes count chips, fast codes count sub-chip ticks
	assign tickSrc = (decRate < RATE_FAST) ? chipTick : subTick;
	assign tickLimit = (decRate < RATE_FAST) ? 4'((4'h1 << decRate[1:0]) - 4'h1) :
		4'(SUB_PER_CHIP >> ({1'b0, decRate[1:0]} + 3'h1));
	assign decNow = tickSrc && (tickCount >= tickLimit);
	assign lowered = {1'b0, threshold} - {1'b0, stepHalfDb};

	always_comb begin
		next_threshold = threshold;
		case (mode)
			RXCFG_FIXED: next_threshold = floorLevel;
			RXCFG_AVERAGE: next_threshold = rssiAverage;
			RXCFG_PEAK: begin
				if (rssi > threshold)
					next_threshold = rssi;
				else if (decNow)
					next_threshold = lowered[DATA_W] ? floorLevel : lowered[DATA_W-1:0];
				// Floor also catches a floor raised by software mid-decay
				if (next_threshold < floorLevel)
					next_threshold = floorLevel;
			end
			default: next_threshold = floorLevel;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			threshold <= RST_FLOOR;
			tickCount <= 4'h0;
		end else begin
			threshold <= next_threshold;
			if (decNow)
				tickCount <= 4'h0;
			else if (tickSrc)
				tickCount <= tickCount + 4'h1;
		end
	end
endmodule : rxcfg_onoff_threshold_floor
`default_nettype wire

// ### core/rxcfg_regbank.sv
// Receiver settings register bank with Avalon-MM slave and receive helpers
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module rxcfg_regbank (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [rxcfg_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [rxcfg_pkg::BUS_W-1:0] avs_writedata,
	output logic [rxcfg_pkg::BUS_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	// Receive datapath inputs
	input wire logic [rxcfg_pkg::DATA_W-1:0] rssi,
	input wire logic [rxcfg_pkg::DATA_W-1:0] rssiAverage,
	input wire rxcfg_pkg::rxcfg_mode_t ookMode,
	input wire logic chipTick,
	input wire logic subTick,
	input wire logic [rxcfg_pkg::SYNC_W-1:0] syncValue,
	input wire logic rxBit,
	input wire logic rxBitValid,
	// Settings to the receive datapath
	output logic [3:0] lowpassBwCode,
	output logic [3:0] rxBandwidthCode,
	output logic [3:0] polyphaseCentreCode,
	output logic polyphaseEnable,
	output logic bitSyncOff,
	output logic [1:0] onoffAverageCutoff,
	// Derived results
	output logic [rxcfg_pkg::DATA_W-1:0] onoffThreshold,
	output logic syncFound,
	output logic strengthAlert
);
	import rxcfg_pkg::*;

	logic [DATA_W-1:0] regAlert;
	logic [DATA_W-1:0] regFilter;
	logic [DATA_W-1:0] regPoly;
	logic [DATA_W-1:0] regSync;
	logic [DATA_W-1:0] regFloor;
	logic [DATA_W-1:0] regRssi;
	logic [DATA_W-1:0] regDyn;
	logic [DATA_W-1:0] ookThreshold;
	logic syncHit;
	// Bus decode nets
	logic [IDX_W-1:0] regIndex;
	logic wordAligned;
	logic busReq;
	logic busTake;
	logic wrLane;
	logic [DATA_W-1:0] wrByte;
	logic selAlert;
	logic selFilter;
	logic selPoly;
	logic selSync;
	logic selFloor;
	logic selRssi;
	logic selDyn;
	logic mapped;
	logic [DATA_W-1:0] rdByte;
	logic [BUS_W-1:0] next_readdata;
	logic rdLoad;
	logic wrAlert;
	logic wrFilter;
	logic wrPoly;
	logic wrSync;
	logic wrFloor;
	logic wrDyn;
	// Bus sequencer
	typedef enum logic {RXCFG_BUS_IDLE, RXCFG_BUS_ANSWER} rxcfg_bus_t;
	rxcfg_bus_t busState;
	rxcfg_bus_t next_busState;
	logic next_waitrequest;
	// Named views of packed fields
	logic syncEnable;
	logic [1:0] syncSize;
	logic [1:0] syncTolerance;
	logic [2:0] decSize;
	logic [2:0] decRate;

	// Bus decode
	assign regIndex = avs_address[ADDR_W-1:2];
	assign wordAligned = (avs_address[1:0] == 2'h0);
	assign busReq = avs_read || avs_write;
	// Request is answered one cycle after it is seen
	assign busTake = busReq && !avs_waitrequest;
	assign wrLane = avs_write && busTake && avs_byteenable[0] && wordAligned;
	// Only lane 0 carries data; upper lanes are ignored
	assign wrByte = avs_writedata[DATA_W-1:0];
	assign selAlert = (regIndex == IDX_ALERT);
	assign selFilter = (regIndex == IDX_FILTER);
	assign selPoly = (regIndex == IDX_POLY);
	assign selSync = (regIndex == IDX_SYNC);
	assign selFloor = (regIndex == IDX_FLOOR);
	assign selRssi = (regIndex == IDX_RSSI);
	assign selDyn = (regIndex == IDX_DYN);
	assign mapped = wordAligned && (selAlert || selFilter || selPoly || selSync ||
		selFloor || selRssi || selDyn);

	// Read mux; unmapped or misaligned reads return zero
	assign rdByte = !mapped ? 8'h00 :
		selAlert ? regAlert :
		selFilter ? regFilter :
		selPoly ? regPoly :
		selSync ? regSync :
		selFloor ? regFloor :
		selRssi ? regRssi : regDyn;
	assign next_readdata = {24'h00_0000, rdByte};
	// Read data latched while the request still waits
	assign rdLoad = avs_read && avs_waitrequest;

	// Write enables per register; the reading register has none
	assign wrAlert = wrLane && selAlert;
	assign wrFilter = wrLane && selFilter;
	assign wrPoly = wrLane && selPoly;
	assign wrSync = wrLane && selSync;
	assign wrFloor = wrLane && selFloor;
	assign wrDyn = wrLane && selDyn;

	// Bus sequencer: one wait cycle, then exactly one accept cycle
	always_comb begin
		next_busState = busState;
		next_waitrequest = 1'b1;
		case (busState)
			RXCFG_BUS_IDLE: begin
				if (busReq) begin
					next_busState = RXCFG_BUS_ANSWER;
					next_waitrequest = 1'b0;
				end
			end
			RXCFG_BUS_ANSWER: begin
				// Master releases here; a back to back request waits again
				next_busState = RXCFG_BUS_IDLE;
			end
			default: begin
				next_busState = RXCFG_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busState <= RXCFG_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			busState <= next_busState;
			avs_waitrequest <= next_waitrequest;
		end
	end

	// Read data stand from the accept cycle until the next read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= '0;
		end else if (rdLoad) begin
			avs_readdata <= next_readdata;
		end
	end

	// Filter bandwidth codes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regFilter <= RST_FILTER;
		end else if (wrFilter) begin
			regFilter <= wrByte;
		end
	end

	// Reserved low nibble stored as written; software keeps it at reset value
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regPoly <= RST_POLY;
		end else if (wrPoly) begin
			regPoly <= wrByte;
		end
	end

	// Sync control
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regSync <= RST_SYNC;
		end else if (wrSync) begin
			regSync <= wrByte;
		end
	end

	// OOK threshold floor
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regFloor <= RST_FLOOR;
		end else if (wrFloor) begin
			regFloor <= wrByte;
		end
	end

	// OOK threshold dynamics
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regDyn <= RST_DYN;
		end else if (wrDyn) begin
			regDyn <= wrByte;
		end
	end

	// Alert level, coded like the strength reading
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regAlert <= RST_ALERT;
		end else if (wrAlert) begin
			regAlert <= wrByte;
		end
	end

	// Strength reading follows the datapath every cycle; bus writes never reach it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regRssi <= 8'h00;
		end else begin
			regRssi <= rssi;
		end
	end

	// Same coding as the reading, so a plain compare suffices
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			strengthAlert <= 1'b0;
		end else begin
			strengthAlert <= (rssi > regAlert);
		end
	end

	// Named views of the packed settings
	assign syncEnable = regSync[F_SYNC_EN];
	assign syncSize = regSync[F_SSIZE_MSB:F_SSIZE_LSB];
	assign syncTolerance = regSync[F_STOL_MSB:F_STOL_LSB];
	assign decSize = regDyn[F_STEP_MSB:F_STEP_LSB];
	assign decRate = regDyn[F_RATE_MSB:F_RATE_LSB];

	// Field outputs straight from the register flops
	assign lowpassBwCode = regFilter[F_HI_MSB:F_HI_LSB];
	assign rxBandwidthCode = regFilter[F_LO_MSB:F_LO_LSB];
	assign polyphaseCentreCode = regPoly[F_HI_MSB:F_HI_LSB];
	// Filter switch comes straight from the sync register bit, whatever the demodulator mode
	assign polyphaseEnable = regSync[F_POLY_EN];
	assign bitSyncOff = regSync[F_BSYNC_OFF];
	// Reserved codes pass through; averaging stage treats them as unsupported
	assign onoffAverageCutoff = regDyn[F_AVG_MSB:F_AVG_LSB];

	// Correlator sees the bit strobe on this clock; no crossing needed
	rxcfg_sync_match u_sync (
		.clk(clk),
		.nrst(nrst),
		.syncEnable(syncEnable),
		.syncSize(syncSize),
		.syncTolerance(syncTolerance),
		.syncValue(syncValue),
		.rxBit(rxBit),
		.rxBitValid(rxBitValid),
		.syncFound(syncHit)
	);

	// Threshold tracker output is already a flop, so it leaves as is
	rxcfg_onoff_threshold_floor u_ook (
		.clk(clk),
		.nrst(nrst),
		.mode(ookMode),
		.floorLevel(regFloor),
		.decSize(decSize),
		.decRate(decRate),
		.chipTick(chipTick),
		.subTick(subTick),
		.rssi(rssi),
		.rssiAverage(rssiAverage),
		.threshold(ookThreshold)
	);

	assign onoffThreshold = ookThreshold;
	assign syncFound = syncHit;
endmodule : rxcfg_regbank
`default_nettype wire

// ### sim/rxcfg_regbank_asserts.sv
// Checker for the receiver settings register bank ports
`timescale 1ns/10ps
`default_nettype none
module rxcfg_regbank_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Datapath
	input wire logic [7:0] rssi,
	input wire logic [7:0] rssiAverage,
	input wire rxcfg_pkg::rxcfg_mode_t ookMode,
	input wire logic rxBitValid,
	// Results
	input wire logic [3:0] lowpassBwCode,
	input wire logic [3:0] rxBandwidthCode,
	input wire logic [3:0] polyphaseCentreCode,
	input wire logic polyphaseEnable,
	input wire logic bitSyncOff,
	input wire logic [1:0] onoffAverageCutoff,
	input wire logic [7:0] onoffThreshold,
	input wire logic syncFound
);
	import rxcfg_pkg::*;
	logic req;
	logic [15:0] fields;
	assign req = avs_read || avs_write;
	assign fields = {lowpassBwCode, rxBandwidthCode, polyphaseCentreCode, polyphaseEnable,
		bitSyncOff, onoffAverageCutoff};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not accepted after one cycle");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("accept lasted more than one cycle");
	idle_wait_a: assert property (!req |=> avs_waitrequest)
		else $error("accept without a request");
	rdata_upper_a: assert property (avs_readdata[31:8] == 24'h00_0000)
		else $error("upper read lanes not zero");
	strength_read_a: assert property (
		avs_read && avs_waitrequest && avs_address == 8'h50 |=> avs_readdata[7:0] == $past(rssi, 2))
		else $error("strength read wrong");
	field_write_a: assert property ($changed(fields) |-> $past(avs_write && !avs_waitrequest))
		else $error("field changed without a write");
	peak_track_a: assert property (
		ookMode == RXCFG_PEAK && rssi > onoffThreshold |=> onoffThreshold == $past(rssi))
		else $error("peak not tracked");
	peak_decay_a: assert property (ookMode == RXCFG_PEAK && $past(ookMode) == RXCFG_PEAK &&
		rssi <= onoffThreshold |=> onoffThreshold <= $past(onoffThreshold) &&
		{1'b0, onoffThreshold} + 9'h00C >= {1'b0, $past(onoffThreshold)})
		else $error("peak decay out of range");
	avg_follow_a: assert property (ookMode == RXCFG_AVERAGE |=> onoffThreshold == $past(rssiAverage))
		else $error("average threshold wrong");
	sync_strobe_a: assert property (syncFound |-> $past(rxBitValid))
		else $error("sync pulse without bit strobe");
	cover property (ookMode == RXCFG_PEAK && rssi > onoffThreshold);
	cover property (syncFound);
	cover property (avs_write && !avs_waitrequest);
endmodule : rxcfg_regbank_asserts
bind rxcfg_regbank rxcfg_regbank_asserts u_asserts (.clk, .nrst, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .rssi, .rssiAverage, .ookMode, .rxBitValid,
	.lowpassBwCode, .rxBandwidthCode, .polyphaseCentreCode, .polyphaseEnable, .bitSyncOff,
	.onoffAverageCutoff, .onoffThreshold, .syncFound);
`default_nettype wire

// ### sim/tb.sv
// Self-checking testbench for the receiver settings register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
	import rxcfg_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0, chipTick = 1'b0, subTick = 1'b0;
	logic rxBit = 1'b0, rxBitValid = 1'b0;
	logic [7:0] avs_address = 8'h00, rssi = 8'h00, rssiAverage = 8'h00, onoffThreshold;
	logic [31:0] avs_writedata = 32'h0000_0000, syncValue = 32'h0000_0000, avs_readdata;
	logic avs_waitrequest, polyphaseEnable, bitSyncOff, syncFound, strengthAlert;
	logic [3:0] lowpassBwCode, rxBandwidthCode, polyphaseCentreCode;
	logic [1:0] onoffAverageCutoff;
	rxcfg_mode_t ookMode = RXCFG_FIXED;
	logic [7:0] expq[$];
	logic [7:0] v[4];
	logic [7:0] adr[4] = '{8'h40, 8'h44, 8'h48, 8'h54};
	int st[8] = '{1, 2, 3, 4, 6, 8, 10, 12};
	int per[8] = '{1, 2, 4, 8, 8, 4, 2, 1};
	int num_errors = 0, n_compared = 0, seed = 4628, pulses = 0, s, f;
	always #5 clk = ~clk;
	rxcfg_regbank u_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_byteenable(4'hF), .avs_writedata, .avs_readdata, .avs_waitrequest, .rssi,
		.rssiAverage, .ookMode, .chipTick, .subTick, .syncValue, .rxBit, .rxBitValid,
		.lowpassBwCode, .rxBandwidthCode, .polyphaseCentreCode, .polyphaseEnable, .bitSyncOff,
		.onoffAverageCutoff, .onoffThreshold, .syncFound, .strengthAlert);
	task give_verdict;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Holds the request until waitrequest is sampled low
	task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (k >= 50) begin
			num_errors++;
			$display("unexpected at %0t: wait ran out, got %h expected %h", $time, k, 0);
			give_verdict();
		end
		@(posedge clk);
	endtask : xfer
	task rd(input logic [7:0] a, input logic [7:0] e);
		expq.push_back(e);
		xfer(1'b0, a, 8'h00);
	endtask : rd
	task tick(input logic sub);
		if (sub) subTick <= 1'b1;
		else chipTick <= 1'b1;
		@(posedge clk);
		subTick <= 1'b0;
		chipTick <= 1'b0;
		@(posedge clk);
	endtask : tick
	// Read data are taken at the accepting edge only
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			if (expq.size() == 0) chk(avs_readdata, 32'hFFFF_FFFF);
			else chk(avs_readdata, {24'h00_0000, expq.pop_front()});
		end
		if (syncFound === 1'b1) pulses++;
	end
	initial begin
		repeat (100_000) @(posedge clk);
		num_errors++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		syncValue <= $random(seed);
		@(posedge clk);
		rd(8'h40, 8'hA3);
		rd(8'h44, 8'h38);
		rd(8'h48, 8'h18);
		rd(8'h4C, 8'h04);
		rd(8'h54, 8'h00);
		rd(8'h3C, 8'h00);
		chk({polyphaseEnable, bitSyncOff, onoffAverageCutoff, onoffThreshold}, 32'h0000_0004);
		for (int i = 0; i < 8; i++) begin
			// Reserved fields keep their reset values
			v[0] = 8'($random(seed));
			v[1] = {4'($random(seed)), 4'h8};
			v[2] = {7'($random(seed)), 1'b0};
			v[3] = {6'($random(seed)), {2{i[0]}}};
			for (int j = 0; j < 4; j++) xfer(1'b1, adr[j], v[j]);
			for (int j = 0; j < 4; j++) rd(adr[j], v[j]);
			chk({lowpassBwCode, rxBandwidthCode, polyphaseCentreCode, polyphaseEnable, bitSyncOff,
				onoffAverageCutoff}, {v[0], v[1][7:4], v[2][7:6], v[3][1:0]});
		end
		rssi <= 8'h5A;
		// The reading register copies the strength one edge later
		@(posedge clk);
		rd(8'h50, 8'h5A);
		xfer(1'b1, 8'h50, 8'hC3);
		rd(8'h50, 8'h5A);
		rd(8'h58, 8'h00);
		xfer(1'b1, 8'h3C, 8'h59);
		chk(strengthAlert, 1);
		rssi <= 8'h59;
		repeat (3) @(posedge clk);
		chk(strengthAlert, 0);
		xfer(1'b1, 8'h4C, 8'h20);
		// Fixed threshold follows the floor one edge after the write lands
		@(posedge clk);
		chk(onoffThreshold, 8'h20);
		ookMode <= RXCFG_AVERAGE;
		rssiAverage <= 8'($random(seed));
		repeat (3) @(posedge clk);
		chk(onoffThreshold, rssiAverage);
		for (int r = 0; r < 8; r++) begin
			ookMode <= RXCFG_FIXED;
			xfer(1'b1, 8'h54, {r[2:0], r[2:0], 2'b00});
			ookMode <= RXCFG_PEAK;
			rssi <= 8'h60;
			repeat (3) @(posedge clk);
			rssi <= 8'h10;
			// Whole periods give a count of decrements free of divider phase
			repeat (2 * per[r]) tick(r > 3);
			chk(onoffThreshold, 8'h60 - 8'(2 * st[r]));
		end
		repeat (10) tick(1'b1);
		chk(onoffThreshold, 8'h20);
		ookMode <= RXCFG_FIXED;
		for (int c = 0; c < 8; c++) begin
			s = c >> 1;
			f = s + c % 2;
			xfer(1'b1, 8'h48, 8'h00);
			xfer(1'b1, 8'h48, {2'b00, 1'b1, s[1:0], s[1:0], 1'b0});
			pulses = 0;
			for (int b = 0; b < 8 * (s + 1); b++) begin
				rxBit <= syncValue[31 - b] ^ (b < f);
				rxBitValid <= 1'b1;
				@(posedge clk);
				rxBitValid <= 1'b0;
				@(posedge clk);
			end
			repeat (2) @(posedge clk);
			chk(pulses, f <= s);
		end
		give_verdict();
	end
endmodule : tb
`default_nettype wire
